// ### hdl/mdr_io_relay.v
/*
 * digital input sensing, demand sync and relay / two-wire pulse output logic.
 * assumes: digIn is an asynchronous pin; alarm, demand-end, log-clear and
 * energy strobes come from logic on clk; register port is single-cycle.
 */
// Added by the designer: strobed register access and the address map.
// How it works
// - count off-to-on edges, clear by command
// - log each input change with seconds stamp
// - input mode: normal, sync or conditional energy
// - one input feeds chosen demand systems
// - input mode resets to normal
// - sync pulse closes interval once armed, starts next
// - no interval boundary without sync pulse
// - 66 minutes silent discards pending demand
// - eleven relay modes, external control default
// - internal control ignores commands except override and off in latched mode
// - setup writes de-energize the relay
// - external normal/latched hold until off command
// - internal normal follows assigned alarm
// - internal latched holds until off or clear
// - external timed: command restarts the timer
// - internal timed: alarm energizes for timer
// - interval end pulses relay for timer
// - absolute modes add both directions
// - directional modes count one direction
// - relay resets to normal, external
// - each output transition is one pulse, max 12/s
`timescale 1ns/10ps
`include "mdr_map.vh"

module mdr_io_relay #(
   parameter NSYS = 3,
   parameter SEC_CYCLES = `MDR_CLK_HZ,
   parameter DEB_CYCLES = (`MDR_CLK_HZ / 1000) * `MDR_DEB_MS,
   parameter GAP_CYCLES = (`MDR_CLK_HZ + `MDR_PULSE_MAX_PER_S - 1) / `MDR_PULSE_MAX_PER_S
) (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire [`MDR_ADDR_W-1:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   input wire digIn,
   input wire alarmActive,
   input wire hiLogClear,
   input wire demandEnd,
   input wire eRealIn,
   input wire eRealOut,
   input wire eReactIn,
   input wire eReactOut,
   input wire eApparent,
   output reg relayOn,
   output reg diLevel,
   output reg condEnergyEn,
   output reg [NSYS-1:0] intervalClose,
   output reg [NSYS-1:0] intervalDiscard,
   output reg logValid,
   output reg [31:0] logTime
);
   localparam TOUT_S = `MDR_SYNC_TIMEOUT_MIN * 60;

   reg rstnMeta, rstnSync, pinMeta, pinSync, logEn, rlInt, syncArmed, syncLost;
   reg ovrActive, ovrLevel, alarmPrev, timing, relayWant;
   reg [31:0] debCnt, diCount, secCnt, nowSec, subCnt, gapCnt, next_rdata;
   reg [1:0] diMode;
   reg [NSYS-1:0] sysSel;
   reg [3:0] rlMode;
   reg [15:0] timerSet, weight, timeLeft;
   reg [11:0] syncAge;
   reg [23:0] acc;
   wire [1:0] inc = energy_units(rlMode, eRealIn, eRealOut, eReactIn, eReactOut, eApparent);

   wire secTick = (secCnt == SEC_CYCLES - 1);
   wire wrCfg = wr && (addr == `MDR_REG_DICFG || addr == `MDR_REG_RLCFG ||
                       addr == `MDR_REG_TIMER || addr == `MDR_REG_WEIGHT);
   wire cmdWr = wr && (addr == `MDR_REG_CMD);
   wire cmdOn = cmdWr && wdata[`MDR_CMD_ON];
   wire cmdOff = cmdWr && wdata[`MDR_CMD_OFF];
   wire alarmRise = alarmActive && !alarmPrev;
   wire diRise = (debCnt == DEB_CYCLES - 1) && pinSync && !diLevel;
   wire diChange = (debCnt == DEB_CYCLES - 1) && (pinSync != diLevel);
   wire syncPulse = diRise && (diMode == `MDR_DI_SYNC);
   wire timedMode = (rlMode == `MDR_RL_TIMED);
   wire eoiMode = (rlMode == `MDR_RL_EOI);
   wire pulseMode = (rlMode >= `MDR_RL_ABS_KWH) && (rlMode <= `MDR_RL_KVARH_OUT);
   // plain on commands (no override) only move the relay under external control
   wire extCmdOn = cmdOn && !rlInt;
   wire timerStart = (timedMode && (rlInt ? alarmRise : extCmdOn)) || (eoiMode && demandEnd);
   wire timerDone = timing && (timeLeft == 16'h0000);

   // one-hot-free count of energy units for the selected pulse mode
   function [1:0] energy_units(input [3:0] mode, input rIn, input rOut, input qIn,
                               input qOut, input app);
      begin
         case (mode)
            `MDR_RL_ABS_KWH: energy_units = {1'b0, rIn} + {1'b0, rOut};
            `MDR_RL_ABS_KVARH: energy_units = {1'b0, qIn} + {1'b0, qOut};
            `MDR_RL_KVAH: energy_units = {1'b0, app};
            `MDR_RL_KWH_IN: energy_units = {1'b0, rIn};
            `MDR_RL_KVARH_IN: energy_units = {1'b0, qIn};
            `MDR_RL_KWH_OUT: energy_units = {1'b0, rOut};
            `MDR_RL_KVARH_OUT: energy_units = {1'b0, qOut};
            default: energy_units = 2'h0;
         endcase
      end
   endfunction

   // reset release through two stages; assertion stays asynchronous
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstnMeta <= 1'b0;
         rstnSync <= 1'b0;
      end else if (ce) begin
         rstnMeta <= 1'b1;
         rstnSync <= rstnMeta;
      end
   end

   always @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
         debCnt <= 32'h0000_0000;
         diLevel <= 1'b0;
      end else if (ce) begin
         pinMeta <= digIn;
         pinSync <= pinMeta;
         // level must stay stable a full filter period before it is taken
         if (pinSync == diLevel) begin
            debCnt <= 32'h0000_0000;
         end else if (debCnt == DEB_CYCLES - 1) begin
            debCnt <= 32'h0000_0000;
            diLevel <= pinSync;
         end else begin
            debCnt <= debCnt + 32'h0000_0001;
         end
      end
   end

   // registers and setup
   always @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         diMode <= `MDR_DI_MODE_RST;
         sysSel <= {NSYS{1'b0}};
         logEn <= 1'b0;
         rlMode <= `MDR_RL_MODE_RST;
         rlInt <= 1'b0;
         timerSet <= `MDR_TIMER_RST;
         weight <= `MDR_WEIGHT_RST;
         rdata <= 32'h0000_0000;
      end else if (ce) begin
         rdata <= rd ? next_rdata : 32'h0000_0000;
         if (wr) begin
            case (addr)
               `MDR_REG_DICFG: begin
                  diMode <= wdata[`MDR_DI_MODE_MSB:`MDR_DI_MODE_LSB];
                  sysSel <= wdata[`MDR_DI_SYS_LSB +: NSYS];
                  logEn <= wdata[`MDR_DI_LOG_BIT];
               end
               `MDR_REG_RLCFG: begin
                  rlMode <= wdata[`MDR_RL_MODE_MSB:`MDR_RL_MODE_LSB];
                  rlInt <= wdata[`MDR_RL_INT_BIT];
               end
               `MDR_REG_TIMER: timerSet <= wdata[15:0];
               `MDR_REG_WEIGHT: weight <= wdata[15:0];
               default: ;
            endcase
         end
      end
   end

   always @* begin
      next_rdata = 32'h0000_0000;
      case (addr)
         `MDR_REG_DICFG: begin
            next_rdata[`MDR_DI_MODE_MSB:`MDR_DI_MODE_LSB] = diMode;
            next_rdata[`MDR_DI_SYS_LSB +: NSYS] = sysSel;
            next_rdata[`MDR_DI_LOG_BIT] = logEn;
         end
         `MDR_REG_RLCFG: begin
            next_rdata[`MDR_RL_MODE_MSB:`MDR_RL_MODE_LSB] = rlMode;
            next_rdata[`MDR_RL_INT_BIT] = rlInt;
         end
         `MDR_REG_TIMER: next_rdata[15:0] = timerSet;
         `MDR_REG_WEIGHT: next_rdata[15:0] = weight;
         `MDR_REG_COUNT: next_rdata = diCount;
         `MDR_REG_STATUS: begin
            next_rdata[`MDR_ST_DI] = diLevel;
            next_rdata[`MDR_ST_RELAY] = relayOn;
            next_rdata[`MDR_ST_OVR] = ovrActive;
            next_rdata[`MDR_ST_LOST] = syncLost;
            next_rdata[`MDR_ST_INSYNC] = syncArmed;
         end
         `MDR_REG_TIME: next_rdata = nowSec;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // input counting, logging, time base, demand sync
   always @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         diCount <= 32'h0000_0000;
         secCnt <= 32'h0000_0000;
         nowSec <= 32'h0000_0000;
         logValid <= 1'b0;
         logTime <= 32'h0000_0000;
         condEnergyEn <= 1'b0;
         syncAge <= 12'h000;
         syncArmed <= 1'b0;
         syncLost <= 1'b0;
         intervalClose <= {NSYS{1'b0}};
         intervalDiscard <= {NSYS{1'b0}};
      end else if (ce) begin
         secCnt <= secTick ? 32'h0000_0000 : secCnt + 32'h0000_0001;
         if (wr && addr == `MDR_REG_TIME) begin
            nowSec <= wdata;
         end else if (secTick) begin
            nowSec <= nowSec + 32'h0000_0001;
         end
         // edge counter; an edge in the clear cycle still counts
         if (diRise) begin
            diCount <= (cmdWr && wdata[`MDR_CMD_CLR]) ? 32'h0000_0001 :
                       diCount + 32'h0000_0001;
         end else if (cmdWr && wdata[`MDR_CMD_CLR]) begin
            diCount <= 32'h0000_0000;
         end
         logValid <= diChange && logEn;
         if (diChange && logEn) begin
            logTime <= nowSec;
         end
         condEnergyEn <= (diMode == `MDR_DI_COND) && diLevel;
         intervalClose <= {NSYS{1'b0}};
         intervalDiscard <= {NSYS{1'b0}};
         if (diMode != `MDR_DI_SYNC) begin
            syncArmed <= 1'b0;
            syncLost <= 1'b0;
            syncAge <= 12'h000;
         end else if (syncPulse) begin
            if (syncArmed) begin
               intervalClose <= sysSel;
            end
            syncArmed <= 1'b1;
            syncLost <= 1'b0;
            syncAge <= 12'h000;
         end else if (syncArmed && secTick) begin
            if (syncAge == TOUT_S - 1) begin
               intervalDiscard <= sysSel;
               syncArmed <= 1'b0;
               syncLost <= 1'b1;
               syncAge <= 12'h000;
            end else begin
               syncAge <= syncAge + 12'h001;
            end
         end
      end
   end

   // relay wish for the non-pulse modes
   always @* begin
      case (rlMode)
         `MDR_RL_NORMAL: relayWant = rlInt ? alarmActive : relayOn;
         `MDR_RL_LATCHED: relayWant = relayOn || (rlInt && alarmActive);
         `MDR_RL_TIMED: relayWant = timing;
         `MDR_RL_EOI: relayWant = timing;
         default: relayWant = 1'b0;
      endcase
   end

   // relay, timer and pulse initiator
   always @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         relayOn <= 1'b0;
         ovrActive <= 1'b0;
         ovrLevel <= 1'b0;
         alarmPrev <= 1'b0;
         timeLeft <= 16'h0000;
         subCnt <= 32'h0000_0000;
         timing <= 1'b0;
         acc <= 24'h00_0000;
         gapCnt <= 32'h0000_0000;
      end else if (ce) begin
         alarmPrev <= alarmActive;
         if (gapCnt != 32'h0000_0000) begin
            gapCnt <= gapCnt - 32'h0000_0001;
         end
         if (timerStart) begin
            timing <= 1'b1;
            timeLeft <= timerSet;
            subCnt <= 32'h0000_0000;
         end else if (timerDone) begin
            timing <= 1'b0;
         end else if (timing) begin
            if (subCnt == SEC_CYCLES - 1) begin
               subCnt <= 32'h0000_0000;
               timeLeft <= timeLeft - 16'h0001;
            end else begin
               subCnt <= subCnt + 32'h0000_0001;
            end
         end
         if (wrCfg) begin
            relayOn <= 1'b0;
            ovrActive <= 1'b0;
            timing <= 1'b0;
            acc <= 24'h00_0000;
         end else if (rlInt && cmdWr && wdata[`MDR_CMD_OVR_ON]) begin
            ovrActive <= 1'b1;
            ovrLevel <= wdata[`MDR_CMD_ON];
            relayOn <= wdata[`MDR_CMD_ON];
         end else if (ovrActive && !(cmdWr && wdata[`MDR_CMD_OVR_OFF]) && rlInt) begin
            relayOn <= ovrLevel;
         end else if (pulseMode) begin
            ovrActive <= 1'b0;
            if (acc + {22'h00_0000, inc} >= {8'h00, weight} && gapCnt == 32'h0000_0000) begin
               acc <= acc + {22'h00_0000, inc} - {8'h00, weight};
               relayOn <= !relayOn;
               gapCnt <= GAP_CYCLES - 1;
            end else begin
               acc <= acc + {22'h00_0000, inc};
            end
         end else begin
            ovrActive <= 1'b0;
            if (extCmdOn && (rlMode == `MDR_RL_NORMAL || rlMode == `MDR_RL_LATCHED)) begin
               relayOn <= 1'b1;
            end else if ((cmdOff && !rlInt && rlMode == `MDR_RL_NORMAL) ||
                         ((cmdOff || (rlInt && hiLogClear)) && rlMode == `MDR_RL_LATCHED)) begin
               // latch released by command or log clear
               relayOn <= 1'b0;
            end else if (timerStart) begin
               relayOn <= 1'b1;
            end else if (timerDone) begin
               relayOn <= 1'b0;
            end else begin
               relayOn <= relayWant;
            end
         end
      end
   end

endmodule // mdr_io_relay

// ### inc/mdr_map.vh
/*
 * register map, field positions, reset values, mode codes and timing figures
 * of the digital input and relay/pulse output block.
 * assumes a 32-bit register port with word-sized registers at small indices.
 */
`ifndef MDR_MAP_VH
`define MDR_MAP_VH

// register addresses
`define MDR_ADDR_W 4
`define MDR_REG_DICFG 4'h0
`define MDR_REG_RLCFG 4'h1
`define MDR_REG_TIMER 4'h2
`define MDR_REG_WEIGHT 4'h3
`define MDR_REG_CMD 4'h4
`define MDR_REG_COUNT 4'h5
`define MDR_REG_STATUS 4'h6
`define MDR_REG_TIME 4'h7

// input configuration fields
`define MDR_DI_MODE_LSB 0
`define MDR_DI_MODE_MSB 1
`define MDR_DI_SYS_LSB 2
`define MDR_DI_LOG_BIT 5
`define MDR_DI_MODE_RST 2'h0
`define MDR_DI_NORMAL 2'h0
`define MDR_DI_SYNC 2'h1
`define MDR_DI_COND 2'h2

// relay configuration fields
`define MDR_RL_MODE_LSB 0
`define MDR_RL_MODE_MSB 3
`define MDR_RL_INT_BIT 4
`define MDR_RL_MODE_RST 4'h0
`define MDR_RL_NORMAL 4'h0
`define MDR_RL_LATCHED 4'h1
`define MDR_RL_TIMED 4'h2
`define MDR_RL_EOI 4'h3
`define MDR_RL_ABS_KWH 4'h4
`define MDR_RL_ABS_KVARH 4'h5
`define MDR_RL_KVAH 4'h6
`define MDR_RL_KWH_IN 4'h7
`define MDR_RL_KVARH_IN 4'h8
`define MDR_RL_KWH_OUT 4'h9
`define MDR_RL_KVARH_OUT 4'hA
`define MDR_TIMER_RST 16'h0000
`define MDR_WEIGHT_RST 16'h0001

// command bits
`define MDR_CMD_ON 0
`define MDR_CMD_OFF 1
`define MDR_CMD_OVR_ON 2
`define MDR_CMD_OVR_OFF 3
`define MDR_CMD_CLR 4

// status bits
`define MDR_ST_DI 0
`define MDR_ST_RELAY 1
`define MDR_ST_OVR 2
`define MDR_ST_LOST 3
`define MDR_ST_INSYNC 4

// timing figures in their own units
`define MDR_CLK_HZ 20000000
`define MDR_DEB_MS 10
`define MDR_SYNC_TIMEOUT_MIN 66
`define MDR_PULSE_MAX_PER_S 12

`endif

// ### verif/mdr_contact_partner.sv
/*
 * far side: a bouncing contact feeding the input pin and a two-wire pulse receiver.
 * assumes target is driven by the bench on rising edges.
 */
`timescale 1ns/10ps
module mdr_contact_partner (
   input wire clk,
   input wire target,
   input wire relayOn,
   output reg digIn,
   output integer edges
);
   reg lastTarget;
   reg lastRelay;
   integer bounce;
   initial begin
      digIn = 1'b0;
      lastTarget = 1'b0;
      lastRelay = 1'b0;
      bounce = 0;
      edges = 0;
   end
   always @(posedge clk) begin
      if (relayOn !== lastRelay) edges <= edges + 1;
      lastRelay <= relayOn;
      // three cycles of chatter after every change, real contacts never switch clean
      if (target !== lastTarget) begin
         bounce <= 3;
         digIn <= ~target;
         lastTarget <= target;
      end else if (bounce > 0) begin
         bounce <= bounce - 1;
         digIn <= bounce[0] ? target : ~target;
      end else digIn <= target;
   end
endmodule // mdr_contact_partner

// ### verif/mdr_io_relay_monitor.sv
/*
 * port assertions and covers for the input sensing and relay block.
 * assumes setup writes only while ce is high, and the bench's gap of 8 cycles.
 */
`timescale 1ns/10ps
`include "mdr_map.vh"
module mdr_io_relay_monitor #(
   parameter NSYS = 3,
   parameter SEC_CYCLES = 20
) (
   input wire clk,
   input wire rstn,
   input wire [`MDR_ADDR_W-1:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire digIn,
   input wire alarmActive,
   input wire hiLogClear,
   input wire demandEnd,
   input wire relayOn,
   input wire diLevel,
   input wire [NSYS-1:0] intervalClose,
   input wire [NSYS-1:0] intervalDiscard,
   input wire logValid
);
   localparam int TON = SEC_CYCLES;
   reg [5:0] diCfg;
   reg [4:0] rlCfg;
   reg [15:0] tmr;
   reg ovr;
   wire cmdWr = wr && addr == `MDR_REG_CMD;
   wire setupWr = wr && addr <= `MDR_REG_WEIGHT;
   // shadow of the setup registers so each property knows the active mode
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         diCfg <= 6'h00;
         rlCfg <= 5'h00;
         tmr <= 16'h0000;
         ovr <= 1'b0;
      end else begin
         if (wr && addr == `MDR_REG_DICFG) diCfg <= wdata[5:0];
         if (wr && addr == `MDR_REG_RLCFG) rlCfg <= wdata[4:0];
         if (wr && addr == `MDR_REG_TIMER) tmr <= wdata[15:0];
         if (setupWr || (cmdWr && wdata[3])) ovr <= 1'b0;
         else if (cmdWr && wdata[2]) ovr <= 1'b1;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   chk_setup_off: assert property (setupWr |=> !relayOn)
      else $error("relay stayed on after a setup write");
   chk_ext_energize: assert property (cmdWr && wdata[4:0] == 5'h01 && rlCfg == 5'h00 |=> relayOn)
      else $error("external energize not obeyed");
   chk_int_follow: assert property (rlCfg == 5'h10 && !ovr && !wr |=> relayOn == $past(alarmActive))
      else $error("internal normal relay does not follow alarm");
   chk_int_ignore: assert property (cmdWr && wdata[2:0] != 3'h0 && !wdata[2] && rlCfg == 5'h10 && !ovr
      |=> relayOn == $past(alarmActive))
      else $error("internal relay obeyed a remote command");
   chk_latch_hold: assert property (rlCfg == 5'h11 && relayOn && !wr && !hiLogClear |=> relayOn)
      else $error("latched relay released without cause");
   chk_timed_len: assert property ($rose(relayOn) && rlCfg == 5'h12 && tmr == 16'h0001
      |-> ##TON relayOn ##1 !relayOn)
      else $error("internal timed pulse has wrong length");
   chk_eoi_start: assert property (demandEnd && rlCfg[3:0] == `MDR_RL_EOI && !wr |=> relayOn)
      else $error("interval end did not energize relay");
   chk_pulse_gap: assert property ($changed(relayOn) && rlCfg[3:0] >= 4'h4 && !wr && !$past(wr)
      |=> $stable(relayOn) [*7])
      else $error("pulse output toggled too fast");
   chk_di_filter: assert property ($rose(diLevel) |-> $past(digIn, 3) && $past(digIn, 6))
      else $error("input level rose without a steady pin");
   chk_log_edge: assert property ($changed(diLevel) && diCfg[5] |-> logValid)
      else $error("input change not logged");
   chk_sync_only: assert property (|intervalClose |-> diLevel && !$past(diLevel)
      && diCfg[1:0] == `MDR_DI_SYNC && intervalClose == diCfg[2 +: NSYS])
      else $error("interval closed without a sync pulse");
   cov_timed: cover property ($rose(relayOn) && rlCfg == 5'h12);
   cov_discard: cover property (|intervalDiscard);
   cov_close: cover property (|intervalClose);
endmodule // mdr_io_relay_monitor

bind mdr_io_relay mdr_io_relay_monitor #(.NSYS(NSYS), .SEC_CYCLES(SEC_CYCLES)) u_mon (
   .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .digIn(digIn),
   .alarmActive(alarmActive), .hiLogClear(hiLogClear), .demandEnd(demandEnd),
   .relayOn(relayOn), .diLevel(diLevel), .intervalClose(intervalClose),
   .intervalDiscard(intervalDiscard), .logValid(logValid));

// ### verif/testbench.sv
/*
 * self-checking bench for the input sensing and relay block.
 * assumes shortened second, debounce and gap counts set at the instance.
 */
`timescale 1ns/10ps
`include "mdr_map.vh"
module testbench;
   localparam SEC = 4;
   reg clk, rstn, ce, wr, rd, alarm, logClr, dEnd, target;
   reg [3:0] addr;
   reg [31:0] wdata, rng;
   reg [4:0] eng, e;
   wire [31:0] rdata, logTime;
   wire relayOn, digIn, diLevel, condEn, logValid;
   wire [2:0] iClose, iDiscard;
   integer edges, failures, compares, closes, logs, n, i, m, k, units, w;
   mdr_io_relay #(.NSYS(3), .SEC_CYCLES(SEC), .DEB_CYCLES(4), .GAP_CYCLES(8)) u_dut (
      .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .digIn(digIn), .alarmActive(alarm), .hiLogClear(logClr),
      .demandEnd(dEnd), .eRealIn(eng[0]), .eRealOut(eng[1]), .eReactIn(eng[2]),
      .eReactOut(eng[3]), .eApparent(eng[4]), .relayOn(relayOn), .diLevel(diLevel),
      .condEnergyEn(condEn), .intervalClose(iClose), .intervalDiscard(iDiscard),
      .logValid(logValid), .logTime(logTime));
   mdr_contact_partner u_far (.clk(clk), .target(target), .relayOn(relayOn), .digIn(digIn),
      .edges(edges));
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // units that a pulse mode must count: bits are realIn, realOut, reactIn, reactOut, apparent
   function integer want(input [3:0] md, input [4:0] v);
      case (md)
         4'h4: want = v[0] + v[1];
         4'h5: want = v[2] + v[3];
         4'h6: want = v[4];
         4'h7: want = v[0];
         4'h8: want = v[2];
         4'h9: want = v[1];
         default: want = v[3];
      endcase
   endfunction
   task report_and_stop;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   task check(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task tick(input integer c);
      repeat (c) @(posedge clk);
   endtask
   task wrReg(input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
         @(negedge clk);
      end
   endtask
   task rdReg(input [3:0] a, input [31:0] exp);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         @(negedge clk);
         check(rdata, exp);
      end
   endtask
   // 0 sets the alarm level, 1 and 2 give one-cycle log-clear or interval-end pulses
   task drive(input [1:0] s, input v);
      begin
         @(posedge clk);
         if (s == 2'd0) alarm <= v;
         else if (s == 2'd1) logClr <= v;
         else dEnd <= v;
         @(posedge clk);
         if (s != 2'd0) begin
            logClr <= 1'b0;
            dEnd <= 1'b0;
         end
         @(negedge clk);
      end
   endtask
   task onLen(input integer exp);
      begin
         k = 0;
         while (relayOn === 1'b1 && k < 999) begin
            @(negedge clk);
            k = k + 1;
         end
         if (k == 999) begin
            failures = failures + 1;
            report_and_stop;
         end
         check(k, exp);
      end
   endtask
   task press(input v);
      begin
         @(posedge clk);
         target <= v;
         tick(20);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (|iClose) closes <= closes + 1;
      if (logValid) logs <= logs + 1;
   end
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      {addr, wdata, wr, rd, alarm, logClr, dEnd, eng, target} = 0;
      {failures, compares, closes, logs} = 0;
      rng = 32'h0000_8c0a;
      tick(10);
      rstn <= 1'b1;
      tick(3);
      rdReg(`MDR_REG_DICFG, 32'h0000_0000);
      rdReg(`MDR_REG_RLCFG, 32'h0000_0000);
      rdReg(`MDR_REG_WEIGHT, 32'h0000_0001);
      wrReg(`MDR_REG_CMD, 32'h0000_0001);
      check(relayOn, 1'b1);
      wrReg(`MDR_REG_TIMER, 32'h0000_0002);
      check(relayOn, 1'b0);
      wrReg(`MDR_REG_RLCFG, 32'h0000_0001);
      wrReg(`MDR_REG_CMD, 32'h0000_0001);
      tick(5);
      check(relayOn, 1'b1);
      wrReg(`MDR_REG_CMD, 32'h0000_0002);
      check(relayOn, 1'b0);
      wrReg(`MDR_REG_RLCFG, 32'h0000_0010);
      wrReg(`MDR_REG_CMD, 32'h0000_0001);
      check(relayOn, 1'b0);
      wrReg(`MDR_REG_CMD, 32'h0000_0005);
      check(relayOn, 1'b1);
      wrReg(`MDR_REG_CMD, 32'h0000_0008);
      check(relayOn, 1'b0);
      drive(2'd0, 1'b1);
      check(relayOn, 1'b1);
      wrReg(`MDR_REG_CMD, 32'h0000_0002);
      check(relayOn, 1'b1);
      drive(2'd0, 1'b0);
      check(relayOn, 1'b0);
      wrReg(`MDR_REG_RLCFG, 32'h0000_0011);
      drive(2'd0, 1'b1);
      drive(2'd0, 1'b0);
      check(relayOn, 1'b1);
      drive(2'd1, 1'b1);
      check(relayOn, 1'b0);
      drive(2'd0, 1'b1);
      drive(2'd0, 1'b0);
      @(posedge clk);
      ce <= 1'b0;
      wrReg(`MDR_REG_CMD, 32'h0000_0002);
      check(relayOn, 1'b1);
      @(posedge clk);
      ce <= 1'b1;
      wrReg(`MDR_REG_CMD, 32'h0000_0002);
      check(relayOn, 1'b0);
      wrReg(`MDR_REG_RLCFG, 32'h0000_0002);
      wrReg(`MDR_REG_CMD, 32'h0000_0001);
      wrReg(`MDR_REG_CMD, 32'h0000_0001);
      onLen(2 * SEC + 1);
      wrReg(`MDR_REG_TIMER, 32'h0000_0001);
      wrReg(`MDR_REG_RLCFG, 32'h0000_0012);
      drive(2'd0, 1'b1);
      onLen(SEC + 1);
      tick(10);
      check(relayOn, 1'b0);
      drive(2'd0, 1'b0);
      wrReg(`MDR_REG_TIMER, 32'h0000_0000);
      wrReg(`MDR_REG_RLCFG, 32'h0000_0003);
      drive(2'd2, 1'b1);
      onLen(1);
      wrReg(`MDR_REG_DICFG, 32'h0000_0020);
      wrReg(`MDR_REG_TIME, 32'h0001_0000);
      rng = xs(rng);
      n = 3 + rng[1:0];
      k = logs;
      for (i = 0; i < n; i = i + 1) begin
         press(1'b1);
         check(diLevel, 1'b1);
         press(1'b0);
      end
      rdReg(`MDR_REG_COUNT, n);
      check(logs - k, 2 * n);
      check(logTime > 32'h0001_0000 && logTime <= 32'h0001_0000 + 11 * n, 1'b1);
      wrReg(`MDR_REG_CMD, 32'h0000_0010);
      rdReg(`MDR_REG_COUNT, 32'h0000_0000);
      wrReg(`MDR_REG_DICFG, 32'h0000_0015);
      k = closes;
      press(1'b1);
      press(1'b0);
      check(closes, k);
      press(1'b1);
      check(closes, k + 1);
      press(1'b0);
      // the arming edge lands 10 cycles into the press, so k counts from it
      k = 30;
      while (iDiscard === 3'b000 && k < 17000) begin
         @(negedge clk);
         k = k + 1;
      end
      if (k == 17000) begin
         failures = failures + 1;
         report_and_stop;
      end
      check(k >= 3959 * SEC && k <= 3960 * SEC + 1, 1'b1);
      check(iDiscard, 3'b101);
      k = closes;
      press(1'b1);
      press(1'b0);
      check(closes, k);
      wrReg(`MDR_REG_DICFG, 32'h0000_0002);
      press(1'b1);
      check(condEn, 1'b1);
      press(1'b0);
      check(condEn, 1'b0);
      for (m = 4; m <= 10; m = m + 1) begin
         rng = xs(rng);
         w = rng[1:0] + 2;
         wrReg(`MDR_REG_WEIGHT, w);
         wrReg(`MDR_REG_RLCFG, m);
         units = 0;
         n = edges;
         for (i = 0; i < 160; i = i + 1) begin
            @(posedge clk);
            rng = xs(rng);
            e = rng[4:0] & rng[9:5] & rng[14:10] & rng[19:15];
            eng <= e;
            units = units + want(m[3:0], e);
         end
         @(posedge clk);
         eng <= 5'h00;
         tick(150);
         check(edges - n, units / w);
      end
      report_and_stop;
   end
endmodule // testbench
